// file: design/eeu_core.sv
// execution unit for the subtract-to-memory, nibble swap, skip, table read
// and xor instructions, with an axi4-lite register file and data memory.
// assumes a same-clock program memory that returns data one clock after
// prog_rd, and a master that keeps to axi4-lite handshakes.
//
// Notes on behaviour
// - subtract-to-memory updates all six flags
// - nibble swap in memory, flags untouched
// - swap into working register, memory untouched
// - zero test rewrites byte, skips when zero
// - taken skip adds dummy cycle, three total
// - copy to working register, skip when zero
// - bit test skips when selected bit clear
// - specific page read: low to memory, high latched
// - last page read uses low pointer only
// - increment low pointer, then specific page read
// - increment low pointer, then last page read
// - xor into working register, zero flag only
// - xor into memory, zero flag only
// - subtract carry clear on borrow, else set
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
module eeu_core (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [eeu_pkg::AXI_AW-1:0]    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [eeu_pkg::AXI_DW-1:0]    s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [eeu_pkg::AXI_AW-1:0]    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [eeu_pkg::AXI_DW-1:0]         s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [eeu_pkg::PROG_AW-1:0]        prog_addr,
  output logic                               prog_rd,
  input  wire logic [eeu_pkg::PROG_DW-1:0]   prog_rdata,
  output logic                               busy,
  output logic                               skip_taken,
  output logic                               instr_done
);
  import eeu_pkg::*;

  // ==========================================================================
  // helpers
  function automatic logic [7:0] swap_nib(input logic [7:0] v);
    return {v[3:0], v[7:4]};
  endfunction : swap_nib

  function automatic logic is_mapped(input logic [7:0] a);
    return a[7:5] == MAP_TOP;
  endfunction : is_mapped

  function automatic logic [31:0] pick_word(input logic [7:0] a, input logic [255:0] bank);
    return bank[{a[4:2], 5'h00} +: 32];
  endfunction : pick_word

  function automatic logic op_legal(input logic [3:0] o);
    return o <= OP_XORM;
  endfunction : op_legal

  function automatic logic op_incr(input logic [3:0] o);
    return (o == OP_ITABRD) || (o == OP_ITABRDL);
  endfunction : op_incr

  function automatic logic op_last(input logic [3:0] o);
    return (o == OP_TABRDL) || (o == OP_ITABRDL);
  endfunction : op_last

  // ==========================================================================
  // state
  eeu_state_t  state;
  eeu_state_t  next_state;
  eeu_cmd_t    cmd;
  eeu_flags_t  flags;
  eeu_flags_t  next_flags;
  logic [7:0]  wreg;
  logic [7:0]  next_wreg;
  logic [7:0]  tplo;
  logic [7:0]  tphi;
  logic [7:0]  tlat;
  logic [7:0]  maddr;
  logic [7:0]  mdata_shadow;
  logic        shadow_pend;
  logic [7:0]  opnd;
  logic        last_skip;
  logic [1:0]  last_cyc;
  logic [7:0]  mem_rdata;

  // ==========================================================================
  // register bus decode
  logic        wr_fire;
  logic [31:0] wr_old;
  logic [31:0] wv;
  logic        wr_cmd;
  logic        wr_wreg;
  logic        wr_stat;
  logic        wr_tplo;
  logic        wr_tphi;
  logic        wr_maddr;
  logic        wr_mdata;
  logic        start;
  logic [7:0]  tplo_eff;
  logic [255:0] bank;
  logic [31:0] status_word;

  assign status_word = {18'h0, last_cyc, 2'b00, last_skip, busy, 2'b00, flags};
  assign bank = {{24'h0, mdata_shadow}, {24'h0, maddr}, {24'h0, tlat}, {24'h0, tphi},
                 {24'h0, tplo}, status_word, {24'h0, wreg}, {16'h0, cmd}};

  // only whole handshakes act; strobed-off lanes keep their old contents
  assign wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign wr_old  = pick_word(s_axi_awaddr, bank);
  assign wv      = {s_axi_wstrb[3] ? s_axi_wdata[31:24] : wr_old[31:24],
                    s_axi_wstrb[2] ? s_axi_wdata[23:16] : wr_old[23:16],
                    s_axi_wstrb[1] ? s_axi_wdata[15:8]  : wr_old[15:8],
                    s_axi_wstrb[0] ? s_axi_wdata[7:0]   : wr_old[7:0]};

  // per-register write selects, address bits 1:0 ignored
  assign wr_cmd   = wr_fire && ({s_axi_awaddr[7:2], 2'b00} == OFF_CMD);
  assign wr_wreg  = wr_fire && ({s_axi_awaddr[7:2], 2'b00} == OFF_WREG);
  assign wr_stat  = wr_fire && ({s_axi_awaddr[7:2], 2'b00} == OFF_STATUS);
  assign wr_tplo  = wr_fire && ({s_axi_awaddr[7:2], 2'b00} == OFF_TPLO);
  assign wr_tphi  = wr_fire && ({s_axi_awaddr[7:2], 2'b00} == OFF_TPHI);
  assign wr_maddr = wr_fire && ({s_axi_awaddr[7:2], 2'b00} == OFF_MADDR);
  assign wr_mdata = wr_fire && ({s_axi_awaddr[7:2], 2'b00} == OFF_MDATA);

  // an unknown opcode is stored but starts nothing
  assign start    = wr_cmd && op_legal(wv[3:0]);
  // low pointer is bumped before the fetch address is formed
  assign tplo_eff = op_incr(wv[3:0]) ? tplo + 8'h01 : tplo;

  // ==========================================================================
  // execution datapath, valid in the exec state
  logic [7:0] m;
  logic [8:0] diff;
  logic [4:0] nib_diff;
  logic [7:0] xor_res;
  logic       is_subm;
  logic       is_swap;
  logic       is_swapa;
  logic       is_sz;
  logic       is_sza;
  logic       is_szbit;
  logic       is_tab;
  logic       is_xor;
  logic       is_xorm;
  logic       skip_hit;
  logic       exec_wb;
  logic [7:0] exec_wdata;
  logic       sub_ov;
  logic       in_exec;

  assign in_exec  = (state == ST_EXEC);
  assign m        = opnd;
  assign is_subm  = cmd.op == OP_SUBM;
  assign is_swap  = cmd.op == OP_SWAP;
  assign is_swapa = cmd.op == OP_SWAPA;
  assign is_sz    = cmd.op == OP_SZ;
  assign is_sza   = cmd.op == OP_SZA;
  assign is_szbit = cmd.op == OP_SZBIT;
  assign is_tab   = (cmd.op == OP_TABRD) || (cmd.op == OP_TABRDL) ||
                    (cmd.op == OP_ITABRD) || (cmd.op == OP_ITABRDL);
  assign is_xor   = cmd.op == OP_XOR;
  assign is_xorm  = cmd.op == OP_XORM;

  // nine-bit difference keeps the borrow, five-bit one the nibble borrow
  assign diff     = {1'b0, wreg} - {1'b0, m};
  assign nib_diff = {1'b0, wreg[3:0]} - {1'b0, m[3:0]};
  assign sub_ov   = (wreg[7] ^ m[7]) & (diff[7] ^ wreg[7]);
  assign xor_res  = wreg ^ m;

  // skip decisions: whole byte zero, or selected bit clear
  assign skip_hit = in_exec && ((((is_sz || is_sza) && (m == 8'h00))) ||
                                (is_szbit && !m[cmd.bit_sel]));

  // memory write-back; the zero test writes the same byte back
  assign exec_wb    = in_exec && (is_subm || is_swap || is_sz || is_tab || is_xorm);
  assign exec_wdata = is_subm ? diff[7:0] :
                      is_swap ? swap_nib(m) :
                      is_tab  ? prog_rdata[7:0] :
                      is_xorm ? xor_res :
                      m;

  // flags: subtract sets all six, xor only z, everything else none
  assign next_flags = !in_exec ? flags :
                      is_subm ? eeu_flags_t'{cmpz: (diff[7:0] == 8'h00),
                                             sgn:  sub_ov ^ diff[7],
                                             ov:   sub_ov,
                                             z:    (diff[7:0] == 8'h00),
                                             ac:   ~nib_diff[4],
                                             c:    ~diff[8]} :
                      (is_xor || is_xorm) ?
                        eeu_flags_t'{cmpz: flags.cmpz, sgn: flags.sgn, ov: flags.ov,
                                     z: (xor_res == 8'h00),
                                     ac: flags.ac, c: flags.c} :
                      flags;

  // working register sources; the swap-to-working path never writes memory
  assign next_wreg = !in_exec ? wreg :
                     is_swapa ? swap_nib(m) :
                     is_sza   ? m :
                     is_xor   ? xor_res :
                     wreg;

  // ==========================================================================
  // data memory port: exec owns it, the bus uses it only while idle
  logic [7:0] mem_addr;
  logic       mem_we;
  logic [7:0] mem_wdata;

  assign mem_addr  = in_exec  ? cmd.addr :
                     wr_cmd   ? wv[15:8] :
                     wr_maddr ? wv[7:0] :
                     maddr;
  assign mem_we    = exec_wb || wr_mdata;
  assign mem_wdata = in_exec ? exec_wdata : wv[7:0];

  eeu_dmem u_dmem (
    .aclk  (aclk),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  // ==========================================================================
  // sequencer: read, exec, then a dummy cycle when a skip is taken
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:  next_state = start ? ST_READ : ST_IDLE;
      ST_READ:  next_state = ST_EXEC;
      ST_EXEC:  next_state = skip_hit ? ST_DUMMY : ST_IDLE;
      ST_DUMMY: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // busy covers every cycle of the instruction; done marks its end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy       <= 1'b0;
      skip_taken <= 1'b0;
      instr_done <= 1'b0;
      last_skip  <= 1'b0;
      last_cyc   <= RST_CYC;
    end else begin
      busy       <= (next_state != ST_IDLE);
      skip_taken <= skip_hit;
      instr_done <= (in_exec && !skip_hit) || (state == ST_DUMMY);
      if (in_exec) begin
        last_skip <= skip_hit;
        last_cyc  <= skip_hit ? CYC_SKIP : CYC_NORMAL;
      end
    end
  end

  // operand capture and program fetch request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opnd      <= RST_BYTE;
      prog_rd   <= 1'b0;
      prog_addr <= {RST_BYTE, RST_BYTE};
    end else begin
      if (state == ST_READ) begin
        opnd <= mem_rdata;
      end
      prog_rd <= start && (wv[3:0] >= OP_TABRD) && (wv[3:0] <= OP_ITABRDL);
      if (start) begin
        prog_addr <= op_last(wv[3:0]) ? {LAST_PAGE_HI, tplo_eff} :
                                        {tphi, tplo_eff};
      end
    end
  end

  // software-visible registers; bus writes only land while idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd   <= eeu_cmd_t'(RST_CMD);
      wreg  <= RST_BYTE;
      flags <= eeu_flags_t'(RST_FLAGS);
      tplo  <= RST_BYTE;
      tphi  <= RST_BYTE;
      tlat  <= RST_BYTE;
      maddr <= RST_BYTE;
    end else begin
      if (wr_cmd) cmd <= eeu_cmd_t'(wv[15:0]);
      wreg  <= wr_wreg ? wv[7:0] : next_wreg;
      flags <= wr_stat ? eeu_flags_t'(wv[5:0]) : next_flags;
      if (wr_tplo) tplo <= wv[7:0];
      else if (start && op_incr(wv[3:0])) tplo <= tplo_eff;
      if (wr_tphi) tphi <= wv[7:0];
      if (in_exec && is_tab) tlat <= prog_rdata[15:8];
      if (wr_maddr) maddr <= wv[7:0];
    end
  end

  // memory window shadow; an instruction writing the same byte leaves it stale
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mdata_shadow <= RST_BYTE;
      shadow_pend  <= 1'b0;
    end else begin
      shadow_pend <= wr_maddr;
      if (wr_mdata) mdata_shadow <= wv[7:0];
      else if (shadow_pend) mdata_shadow <= mem_rdata;
    end
  end

  // ==========================================================================
  // axi4-lite write channel: takes address and data together while idle,
  // which also stalls any write that would race a running instruction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                       !s_axi_bvalid && (state == ST_IDLE) && !start;
      s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                       !s_axi_bvalid && (state == ST_IDLE) && !start;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read channel: data latched with the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= {AXI_DW{1'b0}};
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= is_mapped(s_axi_araddr) ? pick_word(s_axi_araddr, bank)
                                                : {AXI_DW{1'b0}};
        s_axi_rresp  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : eeu_core

// file: design/eeu_dmem.sv
// data memory for the execution unit: one port, synchronous write,
// read data from a register one clock after the address.
// assumes the caller never reads and writes different words in one cycle.
`timescale 1ns/10ps
module eeu_dmem (
  input  wire logic                      aclk,
  input  wire logic                      we,
  input  wire logic [eeu_pkg::DMEM_AW-1:0] addr,
  input  wire logic [7:0]                wdata,
  output logic      [7:0]                rdata
);
  import eeu_pkg::*;

  // ==========================================================================
  // storage
  logic [7:0] mem [0:(1<<DMEM_AW)-1];

  // read first, read data registered; no reset on the array itself
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule : eeu_dmem

// file: design/eeu_pkg.sv
// package for the extended instruction execution unit: register map,
// field layouts, reset values, opcodes, states and cycle counts.
// assumes a 32-bit axi4-lite register bus with byte addresses.
package eeu_pkg;

  // ==========================================================================
  // bus and memory geometry
  localparam int          AXI_AW       = 8;
  localparam int          AXI_DW       = 32;
  localparam int          DMEM_AW      = 8;
  localparam int          PROG_AW      = 16;
  localparam int          PROG_DW      = 16;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0]  OFF_CMD      = 8'h00;
  localparam logic [7:0]  OFF_WREG     = 8'h04;
  localparam logic [7:0]  OFF_STATUS   = 8'h08;
  localparam logic [7:0]  OFF_TPLO     = 8'h0c;
  localparam logic [7:0]  OFF_TPHI     = 8'h10;
  localparam logic [7:0]  OFF_TLAT     = 8'h14;
  localparam logic [7:0]  OFF_MADDR    = 8'h18;
  localparam logic [7:0]  OFF_MDATA    = 8'h1c;
  localparam logic [2:0]  MAP_TOP      = 3'h0;   // offsets above 0x1f are unmapped

  // ==========================================================================
  // status word fields
  localparam int          STAT_FLAG_LSB = 0;
  localparam int          STAT_BUSY_BIT = 8;
  localparam int          STAT_SKIP_BIT = 9;
  localparam int          STAT_CYC_LSB  = 12;

  // ==========================================================================
  // reset values and constants
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [15:0] RST_CMD      = 16'h0000;
  localparam logic [5:0]  RST_FLAGS    = 6'h00;
  localparam logic [1:0]  RST_CYC      = 2'h0;
  localparam logic [7:0]  LAST_PAGE_HI = 8'hff;  // high address byte of the final page
  localparam logic [1:0]  CYC_NORMAL   = 2'h2;
  localparam logic [1:0]  CYC_SKIP     = 2'h3;

  // ==========================================================================
  // opcodes
  typedef enum logic [3:0] {
    OP_SUBM    = 4'h0,
    OP_SWAP    = 4'h1,
    OP_SWAPA   = 4'h2,
    OP_SZ      = 4'h3,
    OP_SZA     = 4'h4,
    OP_SZBIT   = 4'h5,
    OP_TABRD   = 4'h6,
    OP_TABRDL  = 4'h7,
    OP_ITABRD  = 4'h8,
    OP_ITABRDL = 4'h9,
    OP_XOR     = 4'ha,
    OP_XORM    = 4'hb
  } eeu_op_t;

  // execution states, gray along idle-read-exec-dummy
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_EXEC  = 2'b11,
    ST_DUMMY = 2'b10
  } eeu_state_t;

  // command word layout: [15:8] address, [6:4] bit select, [3:0] opcode
  typedef struct packed {
    logic [7:0] addr;
    logic       pad;
    logic [2:0] bit_sel;
    eeu_op_t    op;
  } eeu_cmd_t;

  // status flags, bit 0 upward: c, ac, z, ov, sgn, cmpz
  typedef struct packed {
    logic cmpz;
    logic sgn;
    logic ov;
    logic z;
    logic ac;
    logic c;
  } eeu_flags_t;

endpackage : eeu_pkg

// file: sim/eeu_core_sva.sv
// assertion checker for the execution unit: instruction timing and bus answers.
// assumes it is bound to eeu_core and sees only that module's ports.
`timescale 1ns/10ps
module eeu_core_sva
  import eeu_pkg::*;
(
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic [AXI_AW-1:0]   s_axi_araddr,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [AXI_DW-1:0]   s_axi_rdata,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic                prog_rd,
  input wire logic                busy,
  input wire logic                skip_taken,
  input wire logic                instr_done
);
  // ==========================================================================
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // instruction timing: two busy cycles, a third only for a taken skip
  AST_BUSY_SPAN: assert property ($rose(busy) |-> busy ##1 busy ##1 (!busy || skip_taken))
    else $error("busy span wrong");
  AST_SKIP_END: assert property (skip_taken |-> busy ##1 (!busy && instr_done))
    else $error("skip cycle not last");
  AST_SKIP_THIRD: assert property (skip_taken |-> $past(busy, 2) && $past(busy))
    else $error("skip not third cycle");
  AST_DONE_AT_END: assert property ($fell(busy) |-> instr_done)
    else $error("done missing at end");
  // program fetch only in the first busy cycle, one pulse
  AST_FETCH_SLOT: assert property (prog_rd |-> busy && !$past(busy) ##1 busy && !prog_rd)
    else $error("program fetch misplaced");
  // ==========================================================================
  // bus answers stand until taken; unmapped reads refused
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h20
    |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read accepted");
  AST_WR_IDLE: assert property (s_axi_awready |-> s_axi_wready && !busy)
    else $error("write accepted while busy");
  COV_SKIP: cover property (skip_taken);
  COV_FETCH: cover property (prog_rd);
  COV_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : eeu_core_sva

bind eeu_core eeu_core_sva eeu_core_sva_i (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prog_rd, .busy, .skip_taken,
  .instr_done);

// file: sim/tb_extended_instruction_execution.sv
// self-checking bench for eeu_core: every op run against a bench model.
// assumes eeu_pkg and the checker are compiled before this file.
`timescale 1ns/10ps
module tb_extended_instruction_execution;
  import eeu_pkg::*;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, prog_rd, busy, skip_taken, instr_done;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb = 4'hf;
  logic [15:0] prog_addr, prog_rdata = 0;
  int          n_mismatch = 0, tests_run = 0, cyc = 0;
  logic [7:0]  mem [256];
  logic [7:0]  wreg, tplo, tphi, tlat = 0, m, a;
  logic [5:0]  flg;
  logic [1:0]  r;

  eeu_core eeu_core_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_rdata(prog_rdata),
    .busy(busy), .skip_taken(skip_taken), .instr_done(instr_done));

  // ==========================================================================
  // clock, timeout, program memory (garbage outside a fetch so stale data shows)
  initial forever #10 aclk = ~aclk;
  function automatic logic [15:0] pm(input logic [15:0] x);
    return {x[7:0] ^ 8'h3c, x[15:8] ^ 8'ha5};
  endfunction : pm
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    prog_rdata <= prog_rd ? pm(prog_addr) : ~prog_rdata;
    if (cyc == 30000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ==========================================================================
  // comparison, verdict and bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  // address and data offered together, each held until its ready edge
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    // a late bready makes the response stand for a few cycles
    repeat (2'($urandom)) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    repeat (2'($urandom)) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic wok(input logic [7:0] ad, input logic [31:0] d);
    logic [1:0] rs;
    wr(ad, d, rs);
    chk(rs, RESP_OKAY);
  endtask : wok
  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  rs;
    rd(ad, d, rs);
    chk(d, exp);
  endtask : rchk

  // ==========================================================================
  // model one op, start it, then compare every visible result
  task automatic run_op(input eeu_op_t op, input logic [2:0] b);
    logic [8:0]  dif;
    logic [15:0] w;
    logic        sk, ov;
    sk = 1'b0;
    case (op)
      OP_SUBM: begin
        dif = {1'b0, wreg} - {1'b0, m};
        ov = (wreg[7] != m[7]) && (dif[7] != wreg[7]);
        flg = {dif[7:0] == 0, ov ^ dif[7], ov, dif[7:0] == 0, wreg[3:0] >= m[3:0], !dif[8]};
        mem[a] = dif[7:0];
      end
      OP_SWAP: mem[a] = {m[3:0], m[7:4]};
      OP_SWAPA: wreg = {m[3:0], m[7:4]};
      OP_SZ: sk = (m == 0);
      OP_SZA: begin
        wreg = m;
        sk = (m == 0);
      end
      OP_SZBIT: sk = !m[b];
      OP_XOR: begin
        wreg = wreg ^ m;
        flg[2] = (wreg == 0);
      end
      OP_XORM: begin
        mem[a] = wreg ^ m;
        flg[2] = (mem[a] == 0);
      end
      default: begin
        if (op == OP_ITABRD || op == OP_ITABRDL) tplo = tplo + 8'h01;
        w = pm((op == OP_TABRD || op == OP_ITABRD) ? {tphi, tplo} : {LAST_PAGE_HI, tplo});
        mem[a] = w[7:0];
        tlat = w[15:8];
      end
    endcase
    wok(OFF_CMD, {16'h0, a, 1'b0, b, op});
    do @(posedge aclk); while (busy);
    rchk(OFF_STATUS, {18'h0, sk ? CYC_SKIP : CYC_NORMAL, 2'b0, sk, 3'b0, flg});
    rchk(OFF_WREG, {24'h0, wreg});
    rchk(OFF_TPLO, {24'h0, tplo});
    rchk(OFF_TLAT, {24'h0, tlat});
    wok(OFF_MADDR, {24'h0, a});
    rchk(OFF_MDATA, {24'h0, mem[a]});
  endtask : run_op

  // ==========================================================================
  // main sequence: reset, map checks, then every op with random and zero data
  initial begin
    logic [31:0] d;
    void'($urandom(68029));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(OFF_STATUS, 32'h0);
    wok(OFF_TLAT, 32'hff);
    rchk(OFF_TLAT, 32'h0);
    wr(8'h24, 32'h5, r);
    chk(r, RESP_SLVERR);
    rd(8'h20, d, r);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    // a cleared strobe lane must leave its byte as it was
    wok(OFF_WREG, 32'h5a);
    wstrb <= 4'he;
    wok(OFF_WREG, 32'ha5);
    wstrb <= 4'hf;
    rchk(OFF_WREG, 32'h5a);
    wok(OFF_CMD, 32'h0c);
    repeat (3) @(posedge aclk);
    chk(busy, 1'b0);
    for (int i = 0; i < 48; i++) begin
      a = 8'($urandom);
      m = (i < 24) ? 8'($urandom) : 8'h00;
      wreg = (i >= 36) ? m : 8'($urandom);
      tplo = (i >= 24) ? 8'hff : 8'($urandom);
      tphi = 8'($urandom);
      flg = 6'($urandom);
      wok(OFF_WREG, {24'h0, wreg});
      wok(OFF_STATUS, {26'h0, flg});
      wok(OFF_TPLO, {24'h0, tplo});
      wok(OFF_TPHI, {24'h0, tphi});
      wok(OFF_MADDR, {24'h0, a});
      wok(OFF_MDATA, {24'h0, m});
      mem[a] = m;
      run_op(eeu_op_t'(i % 12), 3'($urandom));
    end
    end_of_test();
  end
endmodule : tb_extended_instruction_execution
